// ### tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin \
    mismatches++; $display("[ERR] %0t %s", $time, m); end end
module tb;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, ce, done, slow;
    logic pin, ovf, c1, c2, ge, p;
    logic [1:0] htrans, s;
    logic [2:0] hsize;
    logic [3:0] lvl;
    logic [31:0] haddr, hwdata, hrdata, d;
    int mismatches = 0;
    int compares = 0;
    int n;
    tgc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .gate_pin(pin),
        .other_timer_ovf(ovf), .cmp_one_synced_out(c1),
        .cmp_two_synced_out(c2), .count_enable(ce), .gate_done(done));
    tgc_partner u_far (.hclk(hclk), .lvl(lvl), .slow(slow),
        .gate_pin(pin), .other_timer_ovf(ovf),
        .cmp_one_synced_out(c1), .cmp_two_synced_out(c2));
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    task automatic conclude;
        if (mismatches == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic wt;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 20) begin
                mismatches++;
                $display("[ERR] %0t bus timeout", $time);
                conclude();
            end
            @(posedge hclk);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= 1'b1;
        wt();
        htrans <= 2'b00;
        hwdata <= {24'h00_0000, v};
        wt();
    endtask
    task automatic rd(input logic [7:0] a);
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= 1'b0;
        wt();
        htrans <= 2'b00;
        wt();
        d = hrdata;
    endtask
    task automatic settle;
        repeat (8) @(posedge hclk);
    endtask
    task automatic pin_to(input logic v);
        lvl[0] <= v;
        settle();
    endtask
    function automatic logic exp_lvl(logic [1:0] s, logic p, logic [3:0] v);
        return p ? v[s] : ~v[s];
    endfunction
    initial begin
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'b010;
        hresetn = 1'b0;
        lvl = 4'h0;
        slow = 1'b0;
        void'($urandom(70255));
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        hsel <= 1'b1;
        rd(8'h00);
        `CHK(d & 32'hFFFF_FFFB, 32'h0000_0000, "ctl reset")
        rd(8'h0C);
        `CHK(d, 32'h0000_0000, "unmapped read")
        wr(8'h04, 8'h01);
        rd(8'h04);
        `CHK(d, 32'h0000_0001, "on readback")
        for (int i = 0; i < 24; i++) begin
            s = i[1:0];
            p = i[2];
            ge = 1'($urandom);
            slow <= 1'($urandom);
            lvl <= 4'($urandom);
            wr(8'h00, {ge, p, 4'h0, s});
            settle();
            rd(8'h00);
            `CHK(d[2], exp_lvl(s, p, lvl), "level")
            `CHK(ce, ~ge | exp_lvl(s, p, lvl), "gated count")
        end
        slow <= 1'b0;
        lvl <= 4'h1;
        wr(8'h04, 8'h00);
        wr(8'h00, 8'hC0);
        settle();
        `CHK(ce, 1'b0, "count while off")
        wr(8'h04, 8'h01);
        wr(8'h00, 8'hE0);
        settle();
        `CHK(ce, 1'b0, "raw gate used")
        for (int k = 1; k < 4; k++) begin
            pin_to(1'b0);
            pin_to(1'b1);
            `CHK(ce, k[0], "toggle step")
        end
        rd(8'h08);
        `CHK(d[4], 1'b1, "toggle state")
        wr(8'h00, 8'hC0);
        rd(8'h08);
        `CHK(d[4], 1'b0, "toggle held clear")
        pin_to(1'b0);
        wr(8'h00, 8'hD0);
        wr(8'h00, 8'hD8);
        rd(8'h00);
        `CHK(d[3], 1'b1, "armed status")
        settle();
        `CHK(ce, 1'b0, "closed before pulse")
        pin_to(1'b1);
        `CHK(ce, 1'b1, "open in pulse")
        rd(8'h08);
        `CHK(d[5], 1'b1, "window view")
        lvl[0] <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 30) begin
            @(posedge hclk);
            n++;
        end
        `CHK(done, 1'b1, "done pulse")
        rd(8'h00);
        `CHK(d[3], 1'b0, "status after pulse")
        pin_to(1'b1);
        `CHK(ce, 1'b0, "second pulse ignored")
        pin_to(1'b0);
        wr(8'h00, 8'h88);
        rd(8'h00);
        `CHK(d[3], 1'b0, "arm without mode")
        wr(8'h00, 8'hD8);
        rd(8'h00);
        `CHK(d[3], 1'b1, "arm with mode")
        wr(8'h00, 8'hD0);
        rd(8'h00);
        `CHK(d[3], 1'b0, "arm aborted")
        conclude();
    end
endmodule
`default_nettype wire

// ### tgc_gate_core.sv
`timescale 1ns/100ps
`default_nettype none
module tgc_gate_core
    import tgc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    tgc_gate_if.core gi
);
    logic prev_in;
    logic prev_tm;
    logic tff;
    logic armed;
    logic open_win;
    logic in_rise;
    logic tm_level;
    logic tm_rise;
    logic tm_fall;

    assign in_rise = gi.gate_in & ~prev_in;
    assign tm_level = gi.toggle_mode ? tff : gi.gate_in;
    assign tm_rise = tm_level & ~prev_tm;
    assign tm_fall = ~tm_level & prev_tm;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_in <= 1'b0;
            prev_tm <= 1'b0;
        end else begin
            prev_in <= gi.gate_in;
            prev_tm <= tm_level;
        end
    end

    // Cleared outside toggle
    // Timer off also clears it, so a restart begins closed
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tff <= 1'b0;
        end else if (!gi.toggle_mode || !gi.counter_on) begin
            tff <= 1'b0;
        end else if (in_rise) begin
            tff <= ~tff;
        end
    end

    // Software arms, hardware clears
    // A write in the clearing cycle wins, so a re-arm is never lost
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            armed <= 1'b0;
        end else if (gi.arm_write) begin
            armed <= gi.arm_value;
        end else if (!gi.single_mode) begin
            armed <= 1'b0;
        end else if (open_win && tm_fall) begin
            armed <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            open_win <= 1'b0;
        end else if (!gi.single_mode) begin
            open_win <= 1'b0;
        end else if (open_win && tm_fall) begin
            open_win <= 1'b0;
        end else if (armed && tm_rise) begin
            open_win <= 1'b1;
        end
    end

    assign gi.status = armed;
    assign gi.toggle_state = tff;
    assign gi.pulse_open = open_win;
    assign gi.gate_out = gi.single_mode ? open_win : tm_level;
    assign gi.done = gi.single_mode & open_win & tm_fall;
endmodule
`default_nettype wire

// ### tgc_gate_if.sv
`timescale 1ns/100ps
`default_nettype none
interface tgc_gate_if;
    logic gate_in;
    logic toggle_mode;
    logic single_mode;
    logic counter_on;
    logic arm_write;
    logic arm_value;
    logic status;
    logic toggle_state;
    logic pulse_open;
    logic gate_out;
    logic done;
    modport ctl (
        output gate_in, toggle_mode, single_mode, counter_on,
        output arm_write, arm_value,
        input status, toggle_state, pulse_open, gate_out, done
    );
    modport core (
        input gate_in, toggle_mode, single_mode, counter_on,
        input arm_write, arm_value,
        output status, toggle_state, pulse_open, gate_out, done
    );
endinterface
`default_nettype wire

// ### tgc_partner.sv
`timescale 1ns/100ps
`default_nettype none
module tgc_partner (
    input wire logic hclk,
    input wire logic [3:0] lvl,
    input wire logic slow,
    output logic gate_pin,
    output logic other_timer_ovf,
    output logic cmp_one_synced_out,
    output logic cmp_two_synced_out
);
    initial begin
        gate_pin = 1'b0;
        cmp_one_synced_out = 1'b0;
        cmp_two_synced_out = 1'b0;
    end
    // Overflow shares the timer clock, so it moves just after an edge
    always_ff @(posedge hclk) begin
        other_timer_ovf <= lvl[1];
    end
    // Async sources land off the clock grid; slow costs up to 3 cycles
    always @(lvl or slow) begin
        gate_pin <= #(slow ? 13.7 : 1.3) lvl[0];
        cmp_one_synced_out <= #(slow ? 11.1 : 2.2) lvl[2];
        cmp_two_synced_out <= #(slow ? 9.6 : 0.7) lvl[3];
    end
endmodule
`default_nettype wire

// ### tgc_pkg.sv
`default_nettype none
package tgc_pkg;
    // Register byte offsets
    localparam logic [7:0] TGC_OFS_GATE_CTRL = 8'h00;
    localparam logic [7:0] TGC_OFS_TIMER_CTRL = 8'h04;
    localparam logic [7:0] TGC_OFS_INPUT_VIEW = 8'h08;
    // Gate control field positions
    localparam int TGC_BIT_GATE_ENABLE = 7;
    localparam int TGC_BIT_POLARITY = 6;
    localparam int TGC_BIT_TOGGLE = 5;
    localparam int TGC_BIT_SINGLE = 4;
    localparam int TGC_BIT_STATUS = 3;
    localparam int TGC_BIT_LEVEL = 2;
    localparam int TGC_BIT_SRC_HI = 1;
    localparam int TGC_BIT_SRC_LO = 0;
    // Timer control and input view field positions
    localparam int TGC_BIT_COUNTER_ON = 0;
    localparam int TGC_BIT_VIEW_PIN = 0;
    localparam int TGC_BIT_VIEW_OVF = 1;
    localparam int TGC_BIT_VIEW_CMP1 = 2;
    localparam int TGC_BIT_VIEW_CMP2 = 3;
    localparam int TGC_BIT_VIEW_TFF = 4;
    localparam int TGC_BIT_VIEW_OPEN = 5;
    // Reset values
    localparam logic [7:0] TGC_RST_GATE_CTRL = 8'h00;
    localparam logic TGC_RST_COUNTER_ON = 1'b0;
    localparam logic [31:0] TGC_RDATA_ZERO = 32'h0000_0000;
    // AHB transfer type bit that marks NONSEQ or SEQ
    localparam int TGC_HTRANS_ACTIVE_BIT = 1;
    localparam logic TGC_HRESP_OKAY = 1'b0;

    typedef enum logic [1:0] {
        TGC_SRC_PIN = 2'b00,
        TGC_SRC_OVERFLOW = 2'b01,
        TGC_SRC_CMP_ONE = 2'b10,
        TGC_SRC_CMP_TWO = 2'b11
    } tgc_src_t;

    typedef enum logic [1:0] {
        TGC_REG_GATE = 2'b00,
        TGC_REG_TIMER = 2'b01,
        TGC_REG_VIEW = 2'b10,
        TGC_REG_NONE = 2'b11
    } tgc_reg_t;
endpackage
`default_nettype wire

// ### tgc_top.sv
// Notes on behaviour
// - Polarity bit picks counting gate level
// - Toggle mode uses toggle flip-flop output
// - Toggle flip-flop held cleared when disabled
// - Toggle flip-flop flips on gate rise
// - Single-pulse mode opens one pulse per arm
// - Status reads one while armed, waiting
// - Status reads zero idle or completed
// - Level bit shows processed gate state
// - Level bit ignores gate enable
// - Source field selects pin, overflow, comparators
//
// Our own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module tgc_top
    import tgc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic gate_pin,
    input wire logic other_timer_ovf,
    input wire logic cmp_one_synced_out,
    input wire logic cmp_two_synced_out,
    output logic count_enable,
    output logic gate_done
);
    tgc_gate_if gi();

    logic pin_meta;
    logic pin_sync;
    logic cmp1_meta;
    logic cmp1_sync;
    logic cmp2_meta;
    logic cmp2_sync;
    logic gate_enable;
    logic gate_polarity;
    logic gate_toggle_mode;
    logic gate_single_pulse_mode;
    logic [1:0] gate_source_select;
    logic counter_on;
    logic wr_pend;
    logic rd_pend;
    tgc_reg_t addr_reg;
    logic addr_taken;
    logic wr_gate;
    logic wr_timer;
    logic selected;
    logic [7:0] gate_ctrl_view;
    logic [7:0] input_view;
    logic [31:0] next_hrdata;

    // Address map lookup shared by reads and writes, done once in the address phase
    function automatic tgc_reg_t decode(input logic [31:0] a);
        tgc_reg_t r;
        r = TGC_REG_NONE;
        if (a[31:8] == 24'h00_0000) begin
            if (a[7:0] == TGC_OFS_GATE_CTRL) begin
                r = TGC_REG_GATE;
            end else if (a[7:0] == TGC_OFS_TIMER_CTRL) begin
                r = TGC_REG_TIMER;
            end else if (a[7:0] == TGC_OFS_INPUT_VIEW) begin
                r = TGC_REG_VIEW;
            end
        end
        return r;
    endfunction

    // Pin and comparators are asynchronous to hclk
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end else begin
            pin_meta <= gate_pin;
            pin_sync <= pin_meta;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmp1_meta <= 1'b0;
            cmp1_sync <= 1'b0;
        end else begin
            cmp1_meta <= cmp_one_synced_out;
            cmp1_sync <= cmp1_meta;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmp2_meta <= 1'b0;
            cmp2_sync <= 1'b0;
        end else begin
            cmp2_meta <= cmp_two_synced_out;
            cmp2_sync <= cmp2_meta;
        end
    end

    // Gate source mux
    // Overflow comes from logic on hclk, so it needs no synchroniser
    always_comb begin
        unique case (tgc_src_t'(gate_source_select))
            TGC_SRC_PIN: selected = pin_sync;
            TGC_SRC_OVERFLOW: selected = other_timer_ovf;
            TGC_SRC_CMP_ONE: selected = cmp1_sync;
            TGC_SRC_CMP_TWO: selected = cmp2_sync;
        endcase
    end

    assign gi.gate_in = gate_polarity ? selected : ~selected;
    assign gi.toggle_mode = gate_toggle_mode;
    assign gi.single_mode = gate_single_pulse_mode;
    assign gi.counter_on = counter_on;
    assign gi.arm_write = wr_gate;
    // Mode bit of the same word, so one write can set mode and arm
    assign gi.arm_value = hwdata[TGC_BIT_STATUS] & hwdata[TGC_BIT_SINGLE];

    tgc_gate_core u_core (
        .hclk(hclk),
        .hresetn(hresetn),
        .gi(gi)
    );

    // AHB address phase accepted
    assign addr_taken = hsel & hready & htrans[TGC_HTRANS_ACTIVE_BIT];
    assign wr_gate = wr_pend & (addr_reg == TGC_REG_GATE);
    assign wr_timer = wr_pend & (addr_reg == TGC_REG_TIMER);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            addr_reg <= TGC_REG_NONE;
        end else if (addr_taken) begin
            wr_pend <= hwrite;
            addr_reg <= decode(haddr);
        end else if (!rd_pend) begin
            wr_pend <= 1'b0;
        end
    end

    // Reads take one wait state so a write just before is seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_pend <= 1'b0;
            hreadyout <= 1'b1;
        end else if (rd_pend) begin
            rd_pend <= 1'b0;
            hreadyout <= 1'b1;
        end else if (addr_taken && !hwrite) begin
            rd_pend <= 1'b1;
            hreadyout <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= TGC_HRESP_OKAY;
        end else begin
            hresp <= TGC_HRESP_OKAY;
        end
    end

    // Writable gate control fields
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gate_enable <= TGC_RST_GATE_CTRL[TGC_BIT_GATE_ENABLE];
            gate_polarity <= TGC_RST_GATE_CTRL[TGC_BIT_POLARITY];
            gate_toggle_mode <= TGC_RST_GATE_CTRL[TGC_BIT_TOGGLE];
            gate_single_pulse_mode <= TGC_RST_GATE_CTRL[TGC_BIT_SINGLE];
            gate_source_select <=
                TGC_RST_GATE_CTRL[TGC_BIT_SRC_HI:TGC_BIT_SRC_LO];
        end else if (wr_gate) begin
            gate_enable <= hwdata[TGC_BIT_GATE_ENABLE];
            gate_polarity <= hwdata[TGC_BIT_POLARITY];
            gate_toggle_mode <= hwdata[TGC_BIT_TOGGLE];
            gate_single_pulse_mode <= hwdata[TGC_BIT_SINGLE];
            gate_source_select <= hwdata[TGC_BIT_SRC_HI:TGC_BIT_SRC_LO];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            counter_on <= TGC_RST_COUNTER_ON;
        end else if (wr_timer) begin
            counter_on <= hwdata[TGC_BIT_COUNTER_ON];
        end
    end

    always_comb begin
        gate_ctrl_view = 8'h00;
        gate_ctrl_view[TGC_BIT_GATE_ENABLE] = gate_enable;
        gate_ctrl_view[TGC_BIT_POLARITY] = gate_polarity;
        gate_ctrl_view[TGC_BIT_TOGGLE] = gate_toggle_mode;
        gate_ctrl_view[TGC_BIT_SINGLE] = gate_single_pulse_mode;
        gate_ctrl_view[TGC_BIT_STATUS] = gi.status;
        gate_ctrl_view[TGC_BIT_LEVEL] = gi.gate_out;
        gate_ctrl_view[TGC_BIT_SRC_HI:TGC_BIT_SRC_LO] = gate_source_select;
    end

    always_comb begin
        input_view = 8'h00;
        input_view[TGC_BIT_VIEW_PIN] = pin_sync;
        input_view[TGC_BIT_VIEW_OVF] = other_timer_ovf;
        input_view[TGC_BIT_VIEW_CMP1] = cmp1_sync;
        input_view[TGC_BIT_VIEW_CMP2] = cmp2_sync;
        input_view[TGC_BIT_VIEW_TFF] = gi.toggle_state;
        input_view[TGC_BIT_VIEW_OPEN] = gi.pulse_open;
    end

    // Unmapped reads return zero with OKAY
    always_comb begin
        next_hrdata = TGC_RDATA_ZERO;
        unique case (addr_reg)
            TGC_REG_GATE: next_hrdata[7:0] = gate_ctrl_view;
            TGC_REG_TIMER: next_hrdata[TGC_BIT_COUNTER_ON] = counter_on;
            TGC_REG_VIEW: next_hrdata[7:0] = input_view;
            TGC_REG_NONE: next_hrdata = TGC_RDATA_ZERO;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= TGC_RDATA_ZERO;
        end else if (rd_pend) begin
            hrdata <= next_hrdata;
        end
    end

    // Counter enable
    // Registered, so the counter sees the gate one cycle late
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_enable <= 1'b0;
        end else begin
            count_enable <= counter_on & (~gate_enable | gi.gate_out);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gate_done <= 1'b0;
        end else begin
            gate_done <= gi.done;
        end
    end
endmodule
`default_nettype wire

// ### tgc_top_chk.sv
`timescale 1ns/100ps
`default_nettype none
module tgc_top_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic count_enable,
    input wire logic gate_done
);
    logic tk;
    logic wp;
    logic on_sh;
    logic ge_sh;
    logic spm_sh;
    logic [7:0] wa;
    assign tk = hsel && hready && htrans[1];
    // Shadow of written bits, as only the ports are visible here
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wp <= 1'b0;
            wa <= 8'h00;
            on_sh <= 1'b0;
            ge_sh <= 1'b0;
            spm_sh <= 1'b0;
        end else begin
            wp <= tk && hwrite;
            wa <= haddr[7:0];
            if (wp && wa == 8'h04) begin
                on_sh <= hwdata[0];
            end
            if (wp && wa == 8'h00) begin
                ge_sh <= hwdata[7];
                spm_sh <= hwdata[4];
            end
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_rd;
        tk && !hwrite;
    endsequence
    sequence s_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    a_read_wait: assert property (s_rd |=> s_wait)
        else $error("read wait state wrong");
    a_write_nowait: assert property (tk && hwrite |=> hreadyout)
        else $error("write stalled");
    a_unmapped_zero: assert property (s_rd ##0 (haddr != 32'h0000_0000
        && haddr != 32'h0000_0004 && haddr != 32'h0000_0008)
        |-> ##2 hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_on_readback: assert property (s_rd ##0 (haddr == 32'h0000_0004)
        |=> ##1 hrdata == {31'h0000_0000, $past(on_sh)})
        else $error("on bit readback wrong");
    a_off_idle: assert property (!on_sh |=> !count_enable)
        else $error("count while off");
    a_free_run: assert property (on_sh && !ge_sh |=> count_enable)
        else $error("no count with gating off");
    a_done_pulse: assert property (gate_done |=> !gate_done)
        else $error("done longer than one cycle");
    a_done_spm: assert property (gate_done |-> $past(spm_sh, 2))
        else $error("done without single pulse mode");
endmodule
bind tgc_top tgc_top_chk u_chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .count_enable(count_enable), .gate_done(gate_done));
`default_nettype wire
